//--- verilog/cvic_pkg.sv
package cvic_pkg;
  // register byte offsets of the controller's own register file
  localparam logic [7:0] CVIC_OFF_CTRL = 8'h00;
  localparam logic [7:0] CVIC_OFF_WDATA = 8'h04;
  localparam logic [7:0] CVIC_OFF_STATUS = 8'h08;
  localparam logic [7:0] CVIC_OFF_ACK = 8'h0c;
  localparam logic [7:0] CVIC_OFF_CHIPCFG = 8'h10;
  // ctrl fields
  localparam int CVIC_CTRL_GO = 0;
  localparam int CVIC_CTRL_KIND = 1;
  localparam int CVIC_CTRL_ADDR = 2;
  localparam int CVIC_CTRL_CHIP = 4;
  // status fields
  localparam int CVIC_ST_BUSY = 0;
  localparam int CVIC_ST_INT = 1;
  localparam int CVIC_ST_SETUP = 2;
  localparam int CVIC_ST_ACKDONE = 3;
  localparam int CVIC_ST_SETUP_DONE = 4;
  localparam int CVIC_ST_ORDER_ERR = 5;
  // device command encoding
  localparam int CVIC_FIRST_WORD_BIT = 4;
  localparam int CVIC_CHAINED_BIT = 1;
  localparam logic [7:0] CVIC_CALL_OPCODE = 8'hcd;
  localparam logic [31:0] CVIC_RESP_OKAY = 32'h0;
  localparam logic [1:0] CVIC_OKAY = 2'h0;
  localparam logic [1:0] CVIC_SLVERR = 2'h2;
  // strobe timing: at 10 MHz one cycle is 100 ns
  localparam int CVIC_CLK_NS = 100;
  localparam int CVIC_STROBE_NS = 420;
  localparam int CVIC_SETUP_NS = 50;
  localparam int CVIC_STROBE_CYC = (CVIC_STROBE_NS + CVIC_CLK_NS - 1) / CVIC_CLK_NS;
  localparam int CVIC_SETUP_CYC = (CVIC_SETUP_NS + CVIC_CLK_NS - 1) / CVIC_CLK_NS;
  localparam int CVIC_CNT_W = 4;

  typedef enum logic [1:0] {
    CVIC_OP_NONE,
    CVIC_OP_WRITE,
    CVIC_OP_READ,
    CVIC_OP_ACK
  } cvic_op_e;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic ack_n;
    logic addr_sel;
  } cvic_strobes_s;
endpackage : cvic_pkg

//--- verilog/cvic_strobe_gen.sv
`timescale 1ns/1ps
// one strobe cycle on the device pins: address setup, pulse, release
module cvic_strobe_gen
  import cvic_pkg::*;
#(
  parameter int SETUP_CYC = CVIC_SETUP_CYC,
  parameter int PULSE_CYC = CVIC_STROBE_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic start,
  input wire cvic_op_e op,
  input wire logic addr_sel,
  input wire logic [7:0] wdata,
  input wire logic [7:0] bus_in,
  output logic busy,
  output logic done,
  output cvic_strobes_s pins,
  output logic [7:0] bus_out,
  output logic bus_oe,
  output logic [7:0] rdata
);
  initial begin
    if (SETUP_CYC < 1 || PULSE_CYC < 1 || SETUP_CYC + PULSE_CYC > 14) begin
      $error("cvic_strobe_gen: timing counts out of range");
    end
  end

  typedef enum logic [1:0] {CVIC_SG_IDLE, CVIC_SG_SETUP, CVIC_SG_PULSE, CVIC_SG_HOLD} cvic_sg_e;
  cvic_sg_e st_q;
  logic [CVIC_CNT_W-1:0] cnt_q;
  cvic_op_e op_q;
  logic sel_q;
  logic [7:0] wd_q;
  logic [7:0] rd_q;
  logic done_q;
  wire last = (cnt_q == CVIC_CNT_W'(1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= CVIC_SG_IDLE;
      cnt_q <= '0;
      op_q <= CVIC_OP_NONE;
      sel_q <= 1'b0;
      wd_q <= 8'h00;
      rd_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        CVIC_SG_IDLE: begin
          if (start) begin
            st_q <= CVIC_SG_SETUP;
            cnt_q <= CVIC_CNT_W'(SETUP_CYC);
            op_q <= op;
            sel_q <= addr_sel;
            wd_q <= wdata;
          end
        end
        CVIC_SG_SETUP: begin
          cnt_q <= cnt_q - CVIC_CNT_W'(1);
          if (last) begin
            st_q <= CVIC_SG_PULSE;
            cnt_q <= CVIC_CNT_W'(PULSE_CYC);
          end
        end
        CVIC_SG_PULSE: begin
          cnt_q <= cnt_q - CVIC_CNT_W'(1);
          // sample device data at the trailing edge of the pulse
          if (last) begin
            st_q <= CVIC_SG_HOLD;
            rd_q <= bus_in;
          end
        end
        CVIC_SG_HOLD: begin
          st_q <= CVIC_SG_IDLE;
          done_q <= 1'b1;
        end
        default: st_q <= CVIC_SG_IDLE;
      endcase
    end
  end

  wire in_pulse = (st_q == CVIC_SG_PULSE);
  wire active = (st_q != CVIC_SG_IDLE);
  assign busy = active;
  assign done = done_q;
  assign rdata = rd_q;
  assign pins.cs_n = !(active && op_q != CVIC_OP_ACK);
  assign pins.wr_n = !(in_pulse && op_q == CVIC_OP_WRITE);
  assign pins.rd_n = !(in_pulse && op_q == CVIC_OP_READ);
  assign pins.ack_n = !(in_pulse && op_q == CVIC_OP_ACK);
  assign pins.addr_sel = sel_q;
  assign bus_out = wd_q;
  assign bus_oe = active && op_q == CVIC_OP_WRITE;
endmodule : cvic_strobe_gen

//--- verilog/cvic_axil_slave.sv
`timescale 1ns/1ps
// single-outstanding axi4-lite slave front end; decode lives in the top
module cvic_axil_slave
  import cvic_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output logic [7:0] wr_addr,
  output logic [31:0] wr_data,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [7:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  logic aw_q, w_q, bv_q, rv_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q, rd_q;
  logic [1:0] br_q, rr_q;

  assign s_awready = !aw_q && !bv_q;
  assign s_wready = !w_q && !bv_q;
  assign s_arready = !rv_q;
  assign s_bvalid = bv_q;
  assign s_bresp = br_q;
  assign s_rvalid = rv_q;
  assign s_rresp = rr_q;
  assign s_rdata = rd_q;
  // partial byte strobes are taken as full words: all fields sit in lane 0
  assign wr_en = aw_q && w_q && !bv_q;
  assign wr_addr = awa_q;
  assign wr_data = wd_q;
  assign rd_en = s_arvalid && s_arready;
  assign rd_addr = s_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      rv_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      rd_q <= 32'h0;
      br_q <= CVIC_OKAY;
      rr_q <= CVIC_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_q <= 1'b1;
        wd_q <= s_wdata;
      end
      if (wr_en) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        br_q <= wr_ok ? CVIC_OKAY : CVIC_SLVERR;
      end
      if (bv_q && s_bready) begin
        bv_q <= 1'b0;
      end
      if (rd_en) begin
        rv_q <= 1'b1;
        rd_q <= rd_data;
        rr_q <= rd_ok ? CVIC_OKAY : CVIC_SLVERR;
      end else if (rv_q && s_rready) begin
        rv_q <= 1'b0;
      end
    end
  end
endmodule : cvic_axil_slave

//--- verilog/cvic_host.sv
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module cvic_host
  import cvic_pkg::*;
#(
  parameter int NCHIP = 8,
  parameter int STROBE_CYC = CVIC_STROBE_CYC,
  parameter int SETUP_CYC = CVIC_SETUP_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [NCHIP-1:0] chip_sel_n,
  output logic wr_n,
  output logic rd_n,
  output logic acknowledge_strobe_n,
  output logic address_select,
  output logic [NCHIP-1:0] master_slave_select,
  input wire logic interrupt,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe
);
  initial begin
    if (NCHIP < 1 || NCHIP > 8) begin
      $error("cvic_host: NCHIP must be 1..8");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file and bus front end
  logic wr_en, rd_en, wr_ok, rd_ok;
  logic [7:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data;
  logic [7:0] wdata_q;
  logic [2:0] master_q;
  logic [2:0] chip_q;
  logic kind_q;
  logic ackmode_q;
  logic sel_q;
  logic go_q;
  logic [7:0] op_byte_q, lo_q, hi_q, rdbyte_q;
  logic ackdone_q, order_err_q;
  logic [NCHIP-1:0] setup_done_q;
  logic [1:0] setup_left_q [NCHIP];

  cvic_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_ok(wr_ok),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == CVIC_OFF_CTRL) || (a == CVIC_OFF_WDATA) || (a == CVIC_OFF_STATUS)
      || (a == CVIC_OFF_ACK) || (a == CVIC_OFF_CHIPCFG);
  endfunction : is_mapped

  typedef enum logic [2:0] {
    CVIC_IDLE, CVIC_CMD, CVIC_ACK1, CVIC_ACK2, CVIC_ACK3
  } cvic_state_e;
  cvic_state_e st_q;
  logic sg_start, sg_busy, sg_done;
  cvic_op_e sg_op;
  logic [7:0] sg_rdata;
  cvic_strobes_s pins;

  wire idle = (st_q == CVIC_IDLE) && !sg_busy && !go_q;
  wire all_setup = &setup_done_q;
  wire ctrl_go = wr_en && wr_addr == CVIC_OFF_CTRL && wr_data[CVIC_CTRL_GO];
  wire go_kind = wr_data[CVIC_CTRL_KIND];
  wire go_ack = ctrl_go && wr_data[CVIC_CTRL_ADDR+1];
  wire go_ok = idle && (!go_ack || all_setup);
  assign wr_ok = is_mapped(wr_addr) && (!ctrl_go || go_ok)
    && wr_addr != CVIC_OFF_STATUS && wr_addr != CVIC_OFF_ACK;
  assign rd_ok = is_mapped(rd_addr);

  wire [31:0] status_w = {26'h0, order_err_q, &setup_done_q, ackdone_q,
    ~all_setup, interrupt, !idle};
  assign rd_data = (rd_addr == CVIC_OFF_CTRL) ?
    {25'h0, chip_q, ackmode_q, sel_q, kind_q, 1'b0} :
    (rd_addr == CVIC_OFF_WDATA) ? {16'h0, rdbyte_q, wdata_q} :
    (rd_addr == CVIC_OFF_STATUS) ? status_w :
    (rd_addr == CVIC_OFF_ACK) ? {8'h00, hi_q, lo_q, op_byte_q} :
    (rd_addr == CVIC_OFF_CHIPCFG) ? {29'h0, master_q} : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // setup tracking per chip
  wire cmd_write_done = sg_done && st_q == CVIC_CMD && sg_op == CVIC_OP_WRITE;
  wire first_word = !sel_q && wdata_q[CVIC_FIRST_WORD_BIT];

  genvar gi;
  generate
    for (gi = 0; gi < NCHIP; gi++) begin : g_chip
      wire hit = cmd_write_done && chip_q == 3'(gi);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          setup_left_q[gi] <= 2'd0;
          setup_done_q[gi] <= 1'b0;
        end else if (hit && first_word) begin
          setup_left_q[gi] <= wdata_q[CVIC_CHAINED_BIT] ? 2'd2 : 2'd1;
          setup_done_q[gi] <= 1'b0;
        end else if (hit && sel_q && setup_left_q[gi] != 2'd0) begin
          setup_left_q[gi] <= setup_left_q[gi] - 2'd1;
          setup_done_q[gi] <= (setup_left_q[gi] == 2'd1);
        end
      end
      assign master_slave_select[gi] = (master_q == 3'(gi));
      assign chip_sel_n[gi] = pins.cs_n || (chip_q != 3'(gi));
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  wire [7:0] cmd_byte = wdata_q;
  assign sg_op = (st_q == CVIC_CMD) ? (kind_q ? CVIC_OP_READ : CVIC_OP_WRITE) :
    (st_q == CVIC_IDLE) ? CVIC_OP_NONE : CVIC_OP_ACK;
  assign sg_start = !sg_busy && !sg_done && st_q != CVIC_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= CVIC_IDLE;
      go_q <= 1'b0;
      wdata_q <= 8'h00;
      master_q <= 3'd0;
      chip_q <= 3'd0;
      kind_q <= 1'b0;
      sel_q <= 1'b0;
      op_byte_q <= 8'h00;
      lo_q <= 8'h00;
      hi_q <= 8'h00;
      rdbyte_q <= 8'h00;
      ackdone_q <= 1'b0;
      order_err_q <= 1'b0;
    end else begin
      if (wr_en && wr_ok && wr_addr == CVIC_OFF_WDATA) begin
        wdata_q <= wr_data[7:0];
      end
      if (wr_en && wr_ok && wr_addr == CVIC_OFF_CHIPCFG) begin
        master_q <= wr_data[2:0];
      end
      if (wr_en && wr_ok && wr_addr == CVIC_OFF_CTRL) begin
        kind_q <= go_kind;
        sel_q <= wr_data[CVIC_CTRL_ADDR];
        chip_q <= wr_data[CVIC_CTRL_CHIP+2:CVIC_CTRL_CHIP];
        go_q <= wr_data[CVIC_CTRL_GO];
        if (wr_data[CVIC_CTRL_GO] && wr_data[CVIC_CTRL_ADDR+1]) begin
          ackdone_q <= 1'b0;
        end
      end
      if (go_q) begin
        go_q <= 1'b0;
        // ack mode starts the pulse train
        st_q <= ackmode_q ? CVIC_ACK1 : CVIC_CMD;
      end
      if (sg_done) begin
        case (st_q)
          CVIC_CMD: begin
            st_q <= CVIC_IDLE;
            if (kind_q) begin
              rdbyte_q <= sg_rdata;
            end
          end
          CVIC_ACK1: begin
            op_byte_q <= sg_rdata;
            if (sg_rdata != CVIC_CALL_OPCODE) begin
              order_err_q <= 1'b1;
              st_q <= CVIC_IDLE;
            end else begin
              st_q <= CVIC_ACK2;
            end
          end
          CVIC_ACK2: begin
            lo_q <= sg_rdata;
            st_q <= CVIC_ACK3;
          end
          CVIC_ACK3: begin
            hi_q <= sg_rdata;
            ackdone_q <= 1'b1;
            st_q <= CVIC_IDLE;
          end
          default: st_q <= CVIC_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ackmode_q <= 1'b0;
    end else if (wr_en && wr_ok && wr_addr == CVIC_OFF_CTRL) begin
      ackmode_q <= wr_data[CVIC_CTRL_ADDR+1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin timing
  // one pulse per ack state
  cvic_strobe_gen #(
    .SETUP_CYC(SETUP_CYC),
    .PULSE_CYC(STROBE_CYC)
  ) u_sg (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(sg_start),
    .op(sg_op),
    .addr_sel(sel_q),
    .wdata(cmd_byte),
    .bus_in(data_in),
    .busy(sg_busy),
    .done(sg_done),
    .pins(pins),
    .bus_out(data_out),
    .bus_oe(data_oe),
    .rdata(sg_rdata)
  );

  assign wr_n = pins.wr_n;
  assign rd_n = pins.rd_n;
  assign acknowledge_strobe_n = pins.ack_n;
  assign address_select = pins.addr_sel;
endmodule : cvic_host

//--- test/cvic_host_props.sv
`timescale 1ns/1ps
module cvic_host_props
  import cvic_pkg::*;
#(
  parameter int NCHIP = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NCHIP-1:0] chip_sel_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic acknowledge_strobe_n,
  input wire logic address_select,
  input wire logic [NCHIP-1:0] master_slave_select,
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // a strobe stays low for the five-cycle pulse, then lets go
  sequence s_low5(logic s);
    (!s)[*5] ##1 s;
  endsequence
  a_one_master: assert property ($onehot(master_slave_select))
    else $error("master select not one-hot");
  a_wr_width: assert property ($fell(wr_n) |-> s_low5(wr_n))
    else $error("write strobe width wrong");
  a_ack_width: assert property ($fell(acknowledge_strobe_n) |-> s_low5(acknowledge_strobe_n))
    else $error("acknowledge pulse width wrong");
  a_wr_drives: assert property (!wr_n |-> data_oe && !(&chip_sel_n))
    else $error("write strobe without bus drive or select");
  a_oe_alone: assert property (data_oe |-> rd_n && acknowledge_strobe_n)
    else $error("bus driven during read or acknowledge");
  a_cs_setup: assert property ($fell(wr_n) |-> !(&$past(chip_sel_n)))
    else $error("select not set up before write");
  a_one_chip: assert property ($onehot0(~chip_sel_n))
    else $error("more than one chip selected");
  a_cmd_stable: assert property (!wr_n ##1 !wr_n |-> $stable(data_out) && $stable(address_select))
    else $error("command changed inside strobe");
  a_ack_no_cmd: assert property (!acknowledge_strobe_n |-> wr_n && !data_oe)
    else $error("command traffic inside acknowledge");
endmodule : cvic_host_props
bind cvic_host cvic_host_props #(.NCHIP(NCHIP)) i_props (.aclk(aclk), .aresetn(aresetn),
  .chip_sel_n(chip_sel_n), .wr_n(wr_n), .rd_n(rd_n), .acknowledge_strobe_n(acknowledge_strobe_n),
  .address_select(address_select), .master_slave_select(master_slave_select),
  .data_out(data_out), .data_oe(data_oe));

//--- test/cvic_dev_model.sv
`timescale 1ns/1ps
module cvic_dev_model
  import cvic_pkg::*;
(
  input wire logic aclk,
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic ack_n,
  input wire logic addr_sel,
  input wire logic msel,
  input wire logic [7:0] dbus,
  input wire logic [7:0] irq_in,
  output logic irq_out,
  output logic [7:0] dq,
  output logic dq_oe
);
  logic wr_p = 1'b1, cs_p = 1'b1, ack_p = 1'b1, a_p = 1'b0;
  logic [7:0] d_p = 8'h00, ir_p = 8'h00, pend = 8'h00, in_service_bits = 8'h00, last = 8'h00;
  logic [7:0] w1 = 8'h00, w2 = 8'h00, npul = 8'h00, top;
  logic [1:0] step = 2'h0, acnt = 2'h0;
  logic [2:0] id = 3'h0, cur = 3'h0, lvl;
  assign top = pend & (~pend + 8'h01);
  always_comb begin
    lvl = 3'h0;
    for (int i = 7; i >= 0; i--) if (pend[i]) lvl = i[2:0];
  end
  // interrupt only once set up and something is pending
  assign irq_out = (|pend) && (step == 2'h3);
  // one byte per pulse; a read shows pending bits, or the cleared mask
  // a released bus shows the inverse of its last byte
  assign dq_oe = (!ack_n && msel) || (!rd_n && !cs_n);
  assign dq = !dq_oe ? ~last : !rd_n ? (addr_sel ? 8'h00 : pend) :
              (acnt == 2'h0) ? CVIC_CALL_OPCODE :
              (acnt == 2'h1) ? {w1[7:5], cur, 2'h0} : w2;
  always @(posedge aclk) begin
    wr_p <= wr_n;
    cs_p <= cs_n;
    ack_p <= ack_n;
    a_p <= addr_sel;
    d_p <= dbus;
    ir_p <= irq_in;
    if (dq_oe) last <= dq;
    // rising request sets its pending bit
    pend <= pend | (irq_in & ~ir_p);
    if (!wr_p && wr_n && !cs_p) begin
      // first word restarts setup and rearms edge sensing
      if (!a_p && d_p[CVIC_FIRST_WORD_BIT]) begin
        w1 <= d_p;
        step <= 2'h1;
        ir_p <= 8'hff;
      end
      // end of service clears the lowest set in-service bit
      else if (!a_p && d_p[5]) in_service_bits <= in_service_bits & (in_service_bits - 8'h01);
      else if (step == 2'h1) begin
        w2 <= d_p;
        step <= w1[CVIC_CHAINED_BIT] ? 2'h2 : 2'h3;
      end else if (step == 2'h2) begin
        id <= d_p[2:0];
        step <= 2'h3;
      end
    end
    // first pulse moves the top request into service
    if (ack_p && !ack_n) begin
      npul <= npul + 8'h01;
      if (acnt == 2'h0) begin
        in_service_bits <= in_service_bits | top;
        pend <= pend & ~top;
        cur <= lvl;
      end
    end
    // pulse position wraps after the third
    if (!ack_p && ack_n) acnt <= (acnt == 2'h2) ? 2'h0 : acnt + 2'h1;
  end
endmodule : cvic_dev_model

//--- test/tb.sv
`timescale 1ns/1ps
module tb
  import cvic_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, wr_n, rd_n, ack_n, a0, intr;
  logic oe, oe0, oe1, int0, int1;
  logic [1:0] bresp, rresp, cs_n, msel, r;
  logic [7:0] awaddr, araddr, din, dout, dq0, dq1, ir0, ir1;
  logic [31:0] wdata, rdata, s;
  int err_total, tests_run;
  assign din = oe0 ? dq0 : (oe1 ? dq1 : (oe ? dout : dq0));
  assign intr = msel[0] ? int0 : int1;
  cvic_host #(.NCHIP(2), .STROBE_CYC(5), .SETUP_CYC(1)) i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(4'hf), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid),
    .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .chip_sel_n(cs_n),
    .wr_n(wr_n), .rd_n(rd_n), .acknowledge_strobe_n(ack_n), .address_select(a0),
    .master_slave_select(msel), .interrupt(intr), .data_in(din), .data_out(dout), .data_oe(oe));
  cvic_dev_model i_dev0 (.aclk(aclk), .cs_n(cs_n[0]), .wr_n(wr_n), .rd_n(rd_n), .ack_n(ack_n),
    .addr_sel(a0), .msel(msel[0]), .dbus(din), .irq_in(ir0), .irq_out(int0), .dq(dq0),
    .dq_oe(oe0));
  cvic_dev_model i_dev1 (.aclk(aclk), .cs_n(cs_n[1]), .wr_n(wr_n), .rd_n(rd_n), .ack_n(ack_n),
    .addr_sel(a0), .msel(msel[1]), .dbus(din), .irq_in(ir1), .irq_out(int1), .dq(dq1),
    .dq_oe(oe1));
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task end_sim;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 400) begin
      chk("wait", 0, 1);
      end_sim();
    end
  endtask : tick
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    int n;
    logic pa, pw;
    n = 0;
    pa = 1'b1;
    pw = 1'b1;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pa || pw) begin
      tick(n);
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do tick(n); while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr
  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do tick(n); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) tick(n);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd
  // one command strobe (k[0] acknowledge run, k[1] status read), then wait until idle
  task cmd(input logic [2:0] c, input logic a, input logic [7:0] b, input logic [1:0] k,
           output logic [1:0] rs);
    int n;
    logic [1:0] q;
    axi_wr(CVIC_OFF_WDATA, {24'h0, b}, q);
    axi_wr(CVIC_OFF_CTRL, {25'h0, c, k[0], a, k[1], 1'b1}, rs);
    n = 0;
    s = 32'h1;
    while (s[CVIC_ST_BUSY]) begin
      axi_rd(CVIC_OFF_STATUS, s, q);
      tick(n);
    end
  endtask : cmd
  //////////////////////////////////////////////////////////////////////////////
  task t_early;
    chk("msel_rst", msel, 2'h1);
    cmd(3'h0, 1'b0, 8'h00, 2'h1, r);
    chk("early_ack", r, CVIC_SLVERR);
    chk("early_pulses", i_dev0.npul, 0);
    axi_rd(8'h14, s, r);
    chk("unmapped", r, CVIC_SLVERR);
    axi_wr(CVIC_OFF_STATUS, 32'h0, r);
    chk("ro_write", r, CVIC_SLVERR);
  endtask : t_early
  task t_setup;
    cmd(3'h0, 1'b0, 8'hb0, 2'h0, r);
    cmd(3'h0, 1'b1, 8'h3c, 2'h0, r);
    chk("single_done", i_dev0.step, 3);
    chk("other_chip", i_dev1.step, 0);
    axi_rd(CVIC_OFF_STATUS, s, r);
    chk("not_all", s[CVIC_ST_SETUP_DONE], 0);
    cmd(3'h1, 1'b0, 8'h12, 2'h0, r);
    cmd(3'h1, 1'b1, 8'h55, 2'h0, r);
    chk("chain_mid", i_dev1.step, 2);
    cmd(3'h1, 1'b0, 8'h12, 2'h0, r);
    chk("restart", i_dev1.step, 1);
    cmd(3'h1, 1'b1, 8'h40, 2'h0, r);
    cmd(3'h1, 1'b1, 8'h01, 2'h0, r);
    chk("chain_w2", i_dev1.w2, 8'h40);
    chk("chain_id", {i_dev1.step, i_dev1.id}, 5'h19);
    axi_rd(CVIC_OFF_STATUS, s, r);
    chk("all_done", s[CVIC_ST_SETUP_DONE], 1);
  endtask : t_setup
  task t_ack;
    int n;
    n = 0;
    ir0 <= 8'h08;
    s = 32'h0;
    while (!s[CVIC_ST_INT]) begin
      axi_rd(CVIC_OFF_STATUS, s, r);
      tick(n);
    end
    cmd(3'h0, 1'b0, 8'h00, 2'h2, r);
    axi_rd(CVIC_OFF_WDATA, s, r);
    chk("pending_read", s, 32'h0800);
    cmd(3'h0, 1'b0, 8'h00, 2'h1, r);
    chk("ack_resp", r, CVIC_OKAY);
    ir0 <= 8'h00;
    chk("in_service", {i_dev0.in_service_bits, i_dev0.pend}, 16'h0800);
    chk("pulses", i_dev0.npul, 3);
    axi_rd(CVIC_OFF_ACK, s, r);
    chk("ack_bytes", s, {8'h00, 8'h3c, 3'h5, 3'h3, 2'h0, CVIC_CALL_OPCODE});
    axi_rd(CVIC_OFF_STATUS, s, r);
    chk("ack_flags", {s[CVIC_ST_ORDER_ERR], s[CVIC_ST_ACKDONE]}, 2'h1);
    axi_rd(CVIC_OFF_CTRL, s, r);
    chk("ctrl_view", s, 32'h8);
    cmd(3'h0, 1'b0, 8'h20, 2'h0, r);
    chk("end_service", i_dev0.in_service_bits, 8'h00);
  endtask : t_ack
  task t_master;
    axi_wr(CVIC_OFF_CHIPCFG, 32'h1, r);
    chk("msel_1", msel, 2'h2);
    axi_wr(CVIC_OFF_CHIPCFG, 32'h0, r);
    chk("msel_0", msel, 2'h1);
  endtask : t_master
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    err_total = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    ir0 = 8'h00;
    ir1 = 8'h00;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_early();
    t_setup();
    t_ack();
    t_master();
    end_sim();
  end
endmodule : tb
